/* rtl/acc_ctrl.v */
`timescale 1ns/1ps
// Overview of operation
// - the converter runs only while the on bit (bit 15) is set.
// - with stop-in-idle set the converter halts while idle is asserted.
// - extended buffer mode takes the address from the dma destination.
// - extended mode select only counts while extended features are on.
// - resolution select picks 12-bit over 10-bit conversions.
// - the output format field picks one of four result encodings.
// - hardware sets and clears sample and done; software sets and clears sample, and only clears done.
// - band gap is requested while the bit is set and the converter active.
// - write mode 10 discards results but flags compare matches.
// - write mode 01 stores on match only, mode 00 stores every result.
// - compare mode chooses outside, inside, greater or less matching.
// - the conversion clock period is the instruction cycle times div+1.
`include "acc_consts.vh"

module acc_ctrl #(
    parameter RAW_W = 12
) (
    input  wire              hclk,
    input  wire              hresetn,
    input  wire              hsel,
    input  wire [11:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output reg  [31:0]       hrdata,
    output reg               hreadyout,
    output reg               hresp,
    input  wire              idle_req,
    input  wire [3:0]        trig_in,
    input  wire [RAW_W-1:0]  raw_result,
    input  wire              scan_last,
    input  wire [15:0]       dma_destination_register,
    input  wire [15:0]       dma_base_addr,
    output reg               converter_run,
    output reg               sample_out,
    output reg               conv_clk_tick,
    output reg               band_gap_enable,
    output reg               store_strobe,
    output reg  [15:0]       store_addr,
    output reg  [15:0]       store_data,
    output reg               event_pulse
);

// =====================================================
// registers
reg  [15:0] ctrl1_q;
reg  [15:0] ctrl5_q;
reg  [7:0]  conversion_clock_divider_q;
reg  [2:0]  buf_sel_q;
reg  [15:0] cmp_lo_q;
reg  [15:0] cmp_hi_q;
reg  [15:0] result_q;
reg         match_seen_q;
reg  [7:0]  div_cnt_q;
reg  [7:0]  tad_cnt_q;
reg  [1:0]  state_q;
reg  [2:0]  trig_sync_q;
reg  [2:0]  idle_sync_q;
reg         trig_hist_q;
reg         idle_hist_q;
reg         icyc_q;
reg         wr_pend_q;
reg  [11:0] addr_q;
reg         rd_pend_q;

localparam [1:0] ST_OFF  = 2'b00;
localparam [1:0] ST_SAMPLE_FLAG = 2'b01;
localparam [1:0] ST_CONV = 2'b10;

// =====================================================
// write and compare mode codes
localparam [1:0] WM_ALL   = 2'b00;
localparam [1:0] WM_MATCH = 2'b01;
localparam [1:0] WM_RSVD  = 2'b11;
localparam [1:0] CM_MORE  = 2'b01;
localparam [1:0] CM_IN    = 2'b10;
localparam [1:0] CM_OUT   = 2'b11;

wire       on        = ctrl1_q[`ACC_C1_ON];
wire       xen       = ctrl1_q[`ACC_C1_XEN];
wire       xbm       = ctrl1_q[`ACC_C1_XBM] & xen;
wire [1:0] fmt       = ctrl1_q[`ACC_C1_FMT_HI:`ACC_C1_FMT_LO];
wire [3:0] trg_src   = ctrl1_q[`ACC_C1_TRG_HI:`ACC_C1_TRG_LO];
wire       auto_sample      = ctrl1_q[`ACC_C1_AUTO_SAMPLE];
wire [1:0] wm        = ctrl5_q[`ACC_C5_WM_HI:`ACC_C5_WM_LO];
wire [1:0] cm        = ctrl5_q[`ACC_C5_CM_HI:`ACC_C5_CM_LO];
wire [1:0] asi       = ctrl5_q[`ACC_C5_ASI_HI:`ACC_C5_ASI_LO];
wire       auto_scan_enable      = ctrl5_q[`ACC_C5_AUTO_SCAN_ENABLE];

// =====================================================
// pin synchronisers: a change counts once stages 2 and 3 agree
wire trig_lvl = (trig_sync_q[2] == trig_sync_q[1]) ? trig_sync_q[2]
                                                   : trig_hist_q;
wire idle_lvl = (idle_sync_q[2] == idle_sync_q[1]) ? idle_sync_q[2]
                                                   : idle_hist_q;
wire halted   = ctrl1_q[`ACC_C1_SIDL] & idle_lvl;
wire active   = on & ~halted;

// =====================================================
// three-flop pin capture; history follows the filtered level
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        trig_sync_q <= 3'h0;
        idle_sync_q <= 3'h0;
        trig_hist_q <= 1'b0;
        idle_hist_q <= 1'b0;
    end else begin
        trig_sync_q <= {trig_sync_q[1:0], trig_in[0] | trig_in[1]};
        idle_sync_q <= {idle_sync_q[1:0], idle_req};
        trig_hist_q <= trig_lvl;
        idle_hist_q <= idle_lvl;
    end
end

// =====================================================
// conversion clock: one instruction cycle is two hclk periods
// counters rest at zero while off, so every start gets a full period
wire tad_tick = active & icyc_q & (div_cnt_q == conversion_clock_divider_q);

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        icyc_q    <= 1'b0;
        div_cnt_q <= `ACC_RST8;
    end else if (!active) begin
        icyc_q    <= 1'b0;
        div_cnt_q <= `ACC_RST8;
    end else begin
        icyc_q <= ~icyc_q;
        if (icyc_q) begin
            if (tad_tick)
                div_cnt_q <= `ACC_RST8;
            else
                div_cnt_q <= div_cnt_q + 8'h01;
        end
    end
end

// =====================================================
// result shaping and compare
function [15:0] fmt_result;
    input [RAW_W-1:0] raw;
    input             res12;
    input [1:0]       f;
    reg   [11:0]      v;
    reg   [11:0]      sv;
    begin
        v  = res12 ? raw[11:0] : {2'b00, raw[9:0]};
        sv = res12 ? (v ^ 12'h800) : (v ^ 12'h200);
        case (f)
            2'b00: fmt_result = {4'h0, v};
            2'b01: fmt_result = res12 ? {{4{sv[11]}}, sv}
                                      : {{6{sv[9]}}, sv[9:0]};
            2'b10: fmt_result = res12 ? {v, 4'h0} : {v[9:0], 6'h00};
            default: fmt_result = res12 ? {~v[11], v[10:0], 4'h0}
                                        : {~v[9], v[8:0], 6'h00};
        endcase
    end
endfunction

wire [15:0] shaped = fmt_result(raw_result,
                                ctrl1_q[`ACC_C1_RES12], fmt);
wire [11:0] cmpv   = ctrl1_q[`ACC_C1_RES12] ? raw_result[11:0]
                                            : {2'b00, raw_result[9:0]};
reg         match;
always @* begin
    case (cm)
        CM_OUT:  match = (cmpv < cmp_lo_q[11:0]) | (cmpv > cmp_hi_q[11:0]);
        CM_IN:   match = (cmpv >= cmp_lo_q[11:0]) & (cmpv <= cmp_hi_q[11:0]);
        CM_MORE: match = cmpv > cmp_lo_q[11:0];
        default: match = cmpv < cmp_lo_q[11:0];
    endcase
end

// =====================================================
// sample / convert sequencer
wire trig_fire = (trg_src == 4'h0) ? (tad_cnt_q == `ACC_SAMPLE_TADS)
               : (trg_src == 4'h1) ? (trig_lvl & ~trig_hist_q)
               : 1'b0;
wire sw_sample_flag   = wr_pend_q & (addr_q == `ACC_OFF_CTRL1);
wire conv_end  = (state_q == ST_CONV) & tad_tick &
                 (tad_cnt_q == `ACC_CONV_TADS);
wire store_ok  = (wm == WM_ALL) | ((wm == WM_MATCH) & match);
reg         ev;
always @* begin
    ev = 1'b0;
    if (conv_end & (wm != WM_RSVD)) begin
        if (!auto_scan_enable)
            ev = 1'b1;
        else begin
            case (asi)
                2'b01:   ev = scan_last;
                2'b10:   ev = match;
                2'b11:   ev = scan_last & (match | match_seen_q);
                default: ev = 1'b0;
            endcase
        end
    end
end

// =====================================================
// registered status outputs, all straight from flops
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        converter_run   <= 1'b0;
        sample_out      <= 1'b0;
        conv_clk_tick   <= 1'b0;
        band_gap_enable <= 1'b0;
        event_pulse     <= 1'b0;
    end else begin
        converter_run   <= active;
        conv_clk_tick   <= tad_tick;
        band_gap_enable <= ctrl5_q[`ACC_C5_BAND_GAP_REQUEST] & active;
        sample_out      <= state_q == ST_SAMPLE_FLAG;
        event_pulse     <= ev;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_q     <= ST_OFF;
        tad_cnt_q   <= `ACC_RST8;
        match_seen_q <= 1'b0;
        result_q    <= `ACC_RST16;
        store_strobe <= 1'b0;
        store_addr  <= `ACC_RST16;
        store_data  <= `ACC_RST16;
    end else begin
        store_strobe <= 1'b0;
        if (!active) begin
            state_q   <= ST_OFF;
            tad_cnt_q <= `ACC_RST8;
        end else begin
            case (state_q)
                ST_OFF: begin
                    tad_cnt_q <= `ACC_RST8;
                    if (auto_sample | (sw_sample_flag & hwdata[`ACC_C1_SAMPLE_FLAG]))
                        state_q <= ST_SAMPLE_FLAG;
                end
                ST_SAMPLE_FLAG: begin
                    if (tad_tick)
                        tad_cnt_q <= tad_cnt_q + 8'h01;
                    if (trig_fire |
                        (sw_sample_flag & ~hwdata[`ACC_C1_SAMPLE_FLAG])) begin
                        state_q   <= ST_CONV;
                        tad_cnt_q <= `ACC_RST8;
                    end
                end
                ST_CONV: begin
                    if (tad_tick)
                        tad_cnt_q <= tad_cnt_q + 8'h01;
                    if (conv_end) begin
                        tad_cnt_q <= `ACC_RST8;
                        state_q <= auto_sample ? ST_SAMPLE_FLAG : ST_OFF;
                        result_q <= shaped;
                        if (scan_last)
                            match_seen_q <= 1'b0;
                        else if (match)
                            match_seen_q <= 1'b1;
                        store_data <= shaped;
                        store_strobe <= store_ok;
                        store_addr <= xbm ? dma_destination_register
                                          : dma_base_addr +
                                            {13'h0000, buf_sel_q};
                    end
                end
                default: state_q <= ST_OFF;
            endcase
        end
    end
end

// =====================================================
// ahb-lite slave: zero wait states, always okay
wire addr_ok = hsel & hready & htrans[1];
wire sw_done_clr = wr_pend_q & (addr_q == `ACC_OFF_CTRL1) &
                   ~hwdata[`ACC_C1_DONE];
wire [15:0] c1_rd = {ctrl1_q[15:2], state_q == ST_SAMPLE_FLAG, ctrl1_q[0]};
wire [15:0] c1_wr = hwdata[15:0] & `ACC_C1_WMASK;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl1_q   <= `ACC_RST16;
        ctrl5_q   <= `ACC_RST16;
        conversion_clock_divider_q <= `ACC_RST8;
        buf_sel_q <= 3'h0;
        cmp_lo_q  <= `ACC_RST16;
        cmp_hi_q  <= `ACC_RST16;
        wr_pend_q <= 1'b0;
        rd_pend_q <= 1'b0;
        addr_q    <= 12'h000;
        hrdata    <= 32'h0000_0000;
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end else begin
        wr_pend_q <= addr_ok & hwrite;
        rd_pend_q <= addr_ok & ~hwrite;
        if (addr_ok)
            addr_q <= haddr;
        if (wr_pend_q) begin
            case (addr_q)
                `ACC_OFF_CTRL1: ctrl1_q[15:1] <= c1_wr[15:1];
                `ACC_OFF_CTRL5: ctrl5_q <= hwdata[15:0] & `ACC_C5_WMASK;
                `ACC_OFF_CTRL3: conversion_clock_divider_q <= hwdata[7:0];
                `ACC_OFF_CTRL4: buf_sel_q <= hwdata[2:0];
                `ACC_OFF_CMPLO: cmp_lo_q <= hwdata[15:0];
                `ACC_OFF_CMPHI: cmp_hi_q <= hwdata[15:0];
                default: ;
            endcase
        end
        // done: hardware set wins over a software clear
        if (conv_end)
            ctrl1_q[`ACC_C1_DONE] <= 1'b1;
        else if (sw_done_clr | (state_q == ST_SAMPLE_FLAG))
            ctrl1_q[`ACC_C1_DONE] <= 1'b0;
        // read data is latched in the address phase: a read right behind
        // a write to the same register still sees the old value
        if (addr_ok & ~hwrite) begin
            case (haddr)
                `ACC_OFF_CTRL1:  hrdata <= {16'h0000, c1_rd};
                `ACC_OFF_CTRL5:  hrdata <= {16'h0000, ctrl5_q};
                `ACC_OFF_CTRL3:  hrdata <= {24'h000000,
                                            conversion_clock_divider_q};
                `ACC_OFF_CTRL4:  hrdata <= {29'h00000000, buf_sel_q};
                `ACC_OFF_STATUS: hrdata <= {28'h0000000, match_seen_q,
                                            halted, state_q};
                `ACC_OFF_CMPLO:  hrdata <= {16'h0000, cmp_lo_q};
                `ACC_OFF_CMPHI:  hrdata <= {16'h0000, cmp_hi_q};
                `ACC_OFF_RESULT: hrdata <= {16'h0000, result_q};
                default:         hrdata <= 32'h0000_0000;
            endcase
        end
    end
end

endmodule // acc_ctrl

/* rtl/acc_consts.vh */
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
// =====================================================
// register byte offsets
`define ACC_OFF_CTRL1      12'h000
`define ACC_OFF_CTRL5      12'h004
`define ACC_OFF_CTRL3      12'h008
`define ACC_OFF_CTRL4      12'h00c
`define ACC_OFF_TRIG       12'h010
`define ACC_OFF_STATUS     12'h014
`define ACC_OFF_CMPLO      12'h018
`define ACC_OFF_CMPHI      12'h01c
`define ACC_OFF_RESULT     12'h020
// =====================================================
// control 1 fields
`define ACC_C1_ON          15
`define ACC_C1_SIDL        13
`define ACC_C1_XBM         12
`define ACC_C1_XEN         11
`define ACC_C1_RES12       10
`define ACC_C1_FMT_HI      9
`define ACC_C1_FMT_LO      8
`define ACC_C1_TRG_HI      7
`define ACC_C1_TRG_LO      4
`define ACC_C1_AUTO_SAMPLE        2
`define ACC_C1_SAMPLE_FLAG        1
`define ACC_C1_DONE        0
`define ACC_C1_WMASK       16'hbff6
// =====================================================
// control 5 fields
`define ACC_C5_AUTO_SCAN_ENABLE        15
`define ACC_C5_BAND_GAP_REQUEST       12
`define ACC_C5_ASI_HI      9
`define ACC_C5_ASI_LO      8
`define ACC_C5_WM_HI       3
`define ACC_C5_WM_LO       2
`define ACC_C5_CM_HI       1
`define ACC_C5_CM_LO       0
`define ACC_C5_WMASK       16'hf30f
// =====================================================
// reset values and timing
`define ACC_RST16          16'h0000
`define ACC_RST8           8'h00
`define ACC_SAMPLE_TADS    8'h03
`define ACC_CONV_TADS      8'h0e
`endif

/* tb/acc_ctrl_monitor.sv */
`timescale 1ns/1ps
// ==========================================
// port checker for the converter control
module acc_monitor (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        converter_run,
    input wire        sample_out,
    input wire        band_gap_enable,
    input wire        store_strobe,
    input wire        event_pulse
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_no_read;
        !(hsel && hready && htrans[1] && !hwrite);
    endsequence
    // one cycle of slack for the registered outputs
    sequence s_off_two;
        !converter_run [*2];
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus stalled or errored");
    chk_upper_zero: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    chk_rdata_hold: assert property (s_no_read |=> $stable(hrdata))
        else $error("read data moved without a read");
    chk_off_quiet: assert property (
        s_off_two |-> !sample_out && !store_strobe)
        else $error("activity while converter off");
    chk_sample_on: assert property ($rose(sample_out) |-> converter_run)
        else $error("sampling started while off");
    chk_bg_run: assert property (band_gap_enable |-> converter_run)
        else $error("band gap requested while inactive");
    chk_store_pulse: assert property (store_strobe |=> !store_strobe)
        else $error("store strobe longer than one cycle");
    chk_event_pulse: assert property (event_pulse |=> !event_pulse)
        else $error("event longer than one cycle");
endmodule // acc_monitor

bind acc_ctrl acc_monitor mon (.*);

/* tb/test_adc_control_compare_logic.sv */
`timescale 1ns/1ps
`include "acc_consts.vh"
// ==========================================
// bench for the converter control
module test_adc_control_compare_logic;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [11:0] haddr = 12'h000;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg         idle_req = 1'b0;
    reg  [11:0] raw = 12'h000;
    reg  [15:0] dst = 16'h0000;
    reg  [3:0]  trig = 4'h0;
    reg         last = 1'b0;
    reg  [19:0] row;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, run, sample_flag, tick, bge, stb, evt;
    wire [15:0] saddr, sdata;
    integer     miscompares = 0;
    integer     num_checks = 0;
    integer     cyc = 0;
    integer     i, n, p0, p3;
    reg  [15:0] rd, got_d, got_a;
    reg         got_s, got_e;
    // wm,cm nibble / expected match / raw; window is 0x100..0x200
    function [19:0] tbl(input integer k);
        case (k)
            0: tbl = 20'h81050;
            1: tbl = 20'h80300;
            2: tbl = 20'h91300;
            3: tbl = 20'h90050;
            4: tbl = 20'ha1150;
            5: tbl = 20'ha0300;
            6: tbl = 20'hb1300;
            7: tbl = 20'hb0150;
            8: tbl = 20'h61150;
            default: tbl = 20'h60300;
        endcase
    endfunction

    always #12.5 hclk = ~hclk;

    acc_ctrl uut (
        .hclk                     (hclk),
        .hresetn                  (hresetn),
        .hsel                     (hsel),
        .haddr                    (haddr),
        .htrans                   (htrans),
        .hwrite                   (hwrite),
        .hsize                    (3'h2),
        .hwdata                   (hwdata),
        .hready                   (hreadyout),
        .hrdata                   (hrdata),
        .hreadyout                (hreadyout),
        .hresp                    (hresp),
        .idle_req                 (idle_req),
        .trig_in                  (trig),
        .raw_result               (raw),
        .scan_last                (last),
        .dma_destination_register (dst),
        .dma_base_addr            (16'h0200),
        .converter_run            (run),
        .sample_out               (sample_flag),
        .conv_clk_tick            (tick),
        .band_gap_enable          (bge),
        .store_strobe             (stb),
        .store_addr               (saddr),
        .store_data               (sdata),
        .event_pulse              (evt)
    );

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard, far above the expected run length
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            test_done;
        end
    end

    task chk(input [15:0] exp, input [15:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task bus(input w, input [11:0] a, input [15:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata[15:0];
    endtask

    task settle;
        repeat (6) @(negedge hclk);
    endtask

    // one conversion; 24 conversion clocks cover sampling and converting
    task conv(input [15:0] c1, input [11:0] r);
        @(posedge hclk);
        raw <= r;
        got_s = 1'b0;
        got_e = 1'b0;
        bus(1'b1, `ACC_OFF_CTRL1, c1);
        bus(1'b1, `ACC_OFF_CTRL1, c1 | 16'h0002);
        n = 0;
        while (n < 24) begin
            @(negedge hclk);
            if (tick === 1'b1) n = n + 1;
            if (stb === 1'b1) begin
                got_s = 1'b1;
                got_d = sdata;
                got_a = saddr;
            end
            if (evt === 1'b1) got_e = 1'b1;
        end
    endtask

    task span(output integer s);
        @(negedge hclk);
        while (tick !== 1'b1) @(negedge hclk);
        s = 0;
        do begin
            @(negedge hclk);
            s = s + 1;
        end while (tick !== 1'b1);
    endtask

    task s_regs;
        bus(1'b0, `ACC_OFF_CTRL1, 16'h0);
        chk(16'h0000, rd);
        bus(1'b1, `ACC_OFF_CTRL1, 16'h7f75);
        bus(1'b0, `ACC_OFF_CTRL1, 16'h0);
        chk(16'h3f74, rd);
        bus(1'b1, `ACC_OFF_CTRL5, 16'hffff);
        bus(1'b0, `ACC_OFF_CTRL5, 16'h0);
        chk(16'hf30f, rd);
        bus(1'b1, 12'h024, 16'hffff);
        bus(1'b0, 12'h024, 16'h0);
        chk(16'h0000, rd);
        bus(1'b1, `ACC_OFF_CTRL5, 16'h0);
        bus(1'b1, `ACC_OFF_CTRL1, 16'h0);
    endtask

    task s_power;
        bus(1'b1, `ACC_OFF_CTRL5, 16'h1000);
        settle;
        chk(16'h0, {15'h0, bge});
        bus(1'b1, `ACC_OFF_CTRL1, 16'h8000);
        settle;
        chk(16'h1, {15'h0, run});
        chk(16'h1, {15'h0, bge});
        bus(1'b1, `ACC_OFF_CTRL5, 16'h0);
        settle;
        chk(16'h0, {15'h0, bge});
        bus(1'b1, `ACC_OFF_CTRL1, 16'ha000);
        idle_req <= 1'b1;
        settle;
        chk(16'h0, {15'h0, run});
        @(posedge hclk);
        idle_req <= 1'b0;
        settle;
        chk(16'h1, {15'h0, run});
        bus(1'b1, `ACC_OFF_CTRL1, 16'h8000);
        idle_req <= 1'b1;
        settle;
        chk(16'h1, {15'h0, run});
        @(posedge hclk);
        idle_req <= 1'b0;
        bus(1'b1, `ACC_OFF_CTRL1, 16'h0);
        settle;
        chk(16'h0, {15'h0, run});
    endtask

    task s_div;
        bus(1'b1, `ACC_OFF_CTRL1, 16'h8000);
        bus(1'b1, `ACC_OFF_CTRL3, 16'h0);
        span(p0);
        bus(1'b1, `ACC_OFF_CTRL3, 16'h3);
        span(p3);
        span(p3);
        chk(16'h0002, 16'(p0));
        chk(16'h0008, 16'(p3));
        bus(1'b1, `ACC_OFF_CTRL3, 16'h0);
    endtask

    task s_conv;
        dst <= 16'h1234;
        conv(16'h8400, 12'habc);
        chk(16'h1, {15'h0, got_s});
        chk(16'h0abc, got_d);
        conv(16'h8600, 12'habc);
        chk(16'habc0, got_d);
        conv(16'h9c00, 12'h123);
        chk(16'h1234, got_a);
        conv(16'h9400, 12'h123);
        chk(16'h0200, got_a);
        bus(1'b1, `ACC_OFF_CMPLO, 16'h0100);
        bus(1'b1, `ACC_OFF_CMPHI, 16'h0200);
        for (i = 0; i < 10; i = i + 1) begin
            row = tbl(i);
            bus(1'b1, `ACC_OFF_CTRL5, {12'h820, row[19:16]});
            conv(16'h8400, row[11:0]);
            if (row[19]) begin
                chk({15'h0, row[12]}, {15'h0, got_e});
                chk(16'h0, {15'h0, got_s});
            end else begin
                chk({15'h0, row[12]}, {15'h0, got_s});
            end
        end
    endtask

    // scan end alone, then scan end together with a compare match
    task s_scan;
        bus(1'b1, `ACC_OFF_CTRL5, 16'h8100);
        conv(16'h8400, 12'h050);
        chk(16'h0, {15'h0, got_e});
        @(posedge hclk);
        last <= 1'b1;
        conv(16'h8400, 12'h050);
        chk(16'h1, {15'h0, got_e});
        bus(1'b1, `ACC_OFF_CTRL5, 16'h8300);
        conv(16'h8400, 12'h300);
        chk(16'h0, {15'h0, got_e});
        conv(16'h8400, 12'h050);
        chk(16'h1, {15'h0, got_e});
        @(posedge hclk);
        last <= 1'b0;
        bus(1'b1, `ACC_OFF_CTRL5, 16'h0000);
    endtask

    // pin trigger ends sampling; auto-sample restarts after a result
    task s_trig;
        bus(1'b1, `ACC_OFF_CTRL1, 16'h8410);
        bus(1'b1, `ACC_OFF_CTRL1, 16'h8412);
        repeat (40) @(negedge hclk);
        chk(16'h1, {15'h0, sample_flag});
        @(posedge hclk);
        trig <= 4'h2;
        got_s = 1'b0;
        repeat (60) begin
            @(negedge hclk);
            if (stb === 1'b1) got_s = 1'b1;
        end
        chk(16'h1, {15'h0, got_s});
        chk(16'h0, {15'h0, sample_flag});
        bus(1'b1, `ACC_OFF_CTRL1, 16'h8404);
        trig <= 4'h0;
        while (stb !== 1'b1) @(negedge hclk);
        repeat (3) @(negedge hclk);
        chk(16'h1, {15'h0, sample_flag});
        bus(1'b1, `ACC_OFF_CTRL1, 16'h0000);
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        s_regs;
        s_power;
        s_div;
        s_conv;
        s_scan;
        s_trig;
        test_done;
    end
endmodule // test_adc_control_compare_logic
